// [scr_fc_gen.sv]
`timescale 1ns/100ps
module scr_fc_gen
(
  // Access kind
  input wire logic sup_mode,
  input wire logic prog_access,
  input wire logic use_alt_src,
  input wire logic use_alt_dst,
  input wire logic [2:0] source_space_code,
  input wire logic [2:0] dest_space_code,
  // Result
  output logic [2:0] fc
);
  import scr_pkg::*;
  wire logic [2:0] auto_fc;
  assign auto_fc = sup_mode ? (prog_access ? SCR_FC_SUP_PROG : SCR_FC_SUP_DATA)
                            : (prog_access ? SCR_FC_USER_PROG : SCR_FC_USER_DATA);
  assign fc = use_alt_src ? source_space_code : (use_alt_dst ? dest_space_code : auto_fc);
endmodule

// [scr_pkg.sv]
package scr_pkg;
  // Control register selector codes on the register port
  localparam logic [3:0] SCR_SEL_INT_SP = 4'h0;
  localparam logic [3:0] SCR_SEL_MST_SP = 4'h1;
  localparam logic [3:0] SCR_SEL_USR_SP = 4'h2;
  localparam logic [3:0] SCR_SEL_ACT_SP = 4'h3;
  localparam logic [3:0] SCR_SEL_STATUS = 4'h4;
  localparam logic [3:0] SCR_SEL_VEC_BASE = 4'h5;
  localparam logic [3:0] SCR_SEL_SRC_SPACE = 4'h6;
  localparam logic [3:0] SCR_SEL_DST_SPACE = 4'h7;
  localparam logic [3:0] SCR_SEL_CACHE = 4'h8;
  localparam logic [3:0] SCR_SEL_FLAGS = 4'h9;
  // Status word fields
  localparam int SCR_ST_TRACE_HI = 15;
  localparam int SCR_ST_TRACE_LO = 14;
  localparam int SCR_ST_SUP = 13;
  localparam int SCR_ST_MST = 12;
  localparam int SCR_ST_MASK_HI = 10;
  localparam int SCR_ST_MASK_LO = 8;
  localparam logic [15:0] SCR_ST_IMPL_MASK = 16'hF71F;
  localparam logic [15:0] SCR_FLAGS_MASK = 16'h001F;
  localparam logic [15:0] SCR_ST_RESET = 16'h2700;
  // Cache control enables
  localparam int SCR_CACHE_DE = 31;
  localparam int SCR_CACHE_IE = 15;
  localparam logic [31:0] SCR_CACHE_MASK = 32'h80008000;
  localparam logic [31:0] SCR_CACHE_RESET = 32'h00000000;
  localparam logic [31:0] SCR_PTR_RESET = 32'h00000000;
  localparam logic [2:0] SCR_FC_RESET = 3'h0;
  localparam logic [31:0] SCR_DATA_RESET = 32'h00000000;
  localparam logic [15:0] SCR_SAVED_RESET = 16'h0000;
  // Function codes
  localparam logic [2:0] SCR_FC_USER_DATA = 3'h1;
  localparam logic [2:0] SCR_FC_USER_PROG = 3'h2;
  localparam logic [2:0] SCR_FC_SUP_DATA = 3'h5;
  localparam logic [2:0] SCR_FC_SUP_PROG = 3'h6;
  // Status word write operations
  typedef enum logic [2:0]
  {
    SCR_OP_MOVE = 3'h0,
    SCR_OP_AND = 3'h1,
    SCR_OP_XOR = 3'h2,
    SCR_OP_OR = 3'h3,
    SCR_OP_RET = 3'h4
  } scr_op_t;
endpackage

// [scr_regs.sv]
// Overview of operation
// - In supervisor mode, master bit picks master stack, else interrupt stack.
// - With supervisor bit clear, the user stack pointer is active.
// - Implicit stack references always use the currently active pointer.
// - Interrupt exception saves the status word, then clears the master bit.
// - Reset leaves master bit clear, selecting the interrupt stack.
// - Only status moves, logic immediates, exception return and interrupt entry change the master bit.
// - Privilege depends only on the supervisor bit, never the master bit.
// - Status word is 16 bits; user mode reaches only the condition flags.
// - Status word holds priority mask, two trace bits, supervisor and master bits.
// - Interrupt and master stack pointers are full 32-bit general registers.
// - Vector address is displacement plus the 32-bit vector base.
// - Two alternate 3-bit space codes override the automatic code when asked.
// - Automatic space code tells program from data and user from supervisor.
// - Cache control holds separate instruction and data enables, no line effects.
// - Reset clears the whole cache control register.
// - Control registers other than the flags selector are reachable only in supervisor mode.
`timescale 1ns/100ps
module scr_regs
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire scr_pkg::scr_op_t reg_op,
  output logic [31:0] reg_rdata,
  output logic priv_fault,
  // Implicit stack access
  input wire logic stk_wr,
  input wire logic [31:0] stk_wdata,
  output logic [31:0] stk_ptr,
  // Exception processing
  input wire logic exc_start,
  input wire logic exc_is_irq,
  input wire logic [2:0] exc_ipl,
  input wire logic [9:0] vec_disp,
  output logic [15:0] saved_status,
  output logic [31:0] vec_addr,
  // Address space generation
  input wire logic prog_access,
  input wire logic use_alt_src,
  input wire logic use_alt_dst,
  output logic [2:0] space_code,
  // Mode and cache outputs
  output logic [15:0] status_word,
  output logic sup_mode,
  output logic icache_en,
  output logic dcache_en
);
  import scr_pkg::*;

  logic [31:0] int_sp_q, int_sp_d;
  logic [31:0] mst_sp_q, mst_sp_d;
  logic [31:0] usr_sp_q, usr_sp_d;
  logic [15:0] stat_q, stat_d;
  logic [31:0] vbase_q, vbase_d;
  logic [2:0] src_fc_q, src_fc_d;
  logic [2:0] dst_fc_q, dst_fc_d;
  logic [31:0] cache_q, cache_d;
  logic [31:0] rdata_q;
  logic fault_q;
  logic [15:0] saved_q;
  logic [31:0] vec_q;
  logic [31:0] stk_q;
  logic [2:0] fc_q;

  wire logic s_bit;
  wire logic m_bit;
  wire logic [31:0] act_ptr;
  wire logic [1:0] act_idx;
  wire logic [2:0] fc_w;
  // Register selects
  wire logic sel_int;
  wire logic sel_mst;
  wire logic sel_usr;
  wire logic sel_act;
  wire logic sel_stat;
  wire logic sel_vbase;
  wire logic sel_src;
  wire logic sel_dst;
  wire logic sel_cache;
  wire logic is_flags;
  wire logic sel_status;
  // Access qualification
  wire logic allowed;
  wire logic wr_ok;
  wire logic rd_ok;
  // Write enables
  wire logic wr_int;
  wire logic wr_mst;
  wire logic wr_usr;
  wire logic wr_vbase;
  wire logic wr_src;
  wire logic wr_dst;
  wire logic wr_cache;
  wire logic wr_status;
  wire logic push_int;
  wire logic push_mst;
  wire logic push_usr;
  // Status word datapath
  wire logic [15:0] st_operand;
  wire logic [15:0] st_result;
  wire logic [15:0] st_written;
  wire logic [15:0] st_exc;
  wire logic [31:0] rd_mux;

  assign s_bit = stat_q[SCR_ST_SUP];
  assign m_bit = stat_q[SCR_ST_MST];

  scr_stack_sel u_stack_sel
  (
    .sup_mode(s_bit),
    .master_mode(m_bit),
    .user_stack_ptr(usr_sp_q),
    .interrupt_stack_ptr(int_sp_q),
    .master_stack_ptr(mst_sp_q),
    .active_ptr(act_ptr),
    .active_idx(act_idx)
  );

  scr_fc_gen u_fc_gen
  (
    .sup_mode(s_bit),
    .prog_access(prog_access),
    .use_alt_src(use_alt_src),
    .use_alt_dst(use_alt_dst),
    .source_space_code(src_fc_q),
    .dest_space_code(dst_fc_q),
    .fc(fc_w)
  );

  // Selector decode
  assign sel_int = (reg_addr == SCR_SEL_INT_SP);
  assign sel_mst = (reg_addr == SCR_SEL_MST_SP);
  assign sel_usr = (reg_addr == SCR_SEL_USR_SP);
  assign sel_act = (reg_addr == SCR_SEL_ACT_SP);
  assign sel_stat = (reg_addr == SCR_SEL_STATUS);
  assign sel_vbase = (reg_addr == SCR_SEL_VEC_BASE);
  assign sel_src = (reg_addr == SCR_SEL_SRC_SPACE);
  assign sel_dst = (reg_addr == SCR_SEL_DST_SPACE);
  assign sel_cache = (reg_addr == SCR_SEL_CACHE);
  assign is_flags = (reg_addr == SCR_SEL_FLAGS);
  assign sel_status = sel_stat | is_flags;

  // Privilege check uses the supervisor bit; the flags selector is always allowed
  assign allowed = s_bit | is_flags;
  assign wr_ok = reg_wr & allowed;
  assign rd_ok = reg_rd & allowed;

  // Active supervisor selector follows the master bit
  assign wr_int = wr_ok & (sel_int | (sel_act & ~m_bit));
  assign wr_mst = wr_ok & (sel_mst | (sel_act & m_bit));
  assign wr_usr = wr_ok & sel_usr;
  assign wr_vbase = wr_ok & sel_vbase;
  assign wr_src = wr_ok & sel_src;
  assign wr_dst = wr_ok & sel_dst;
  assign wr_cache = wr_ok & sel_cache;
  assign wr_status = wr_ok & sel_status;

  // Implicit stack writes go to the active pointer
  assign push_int = stk_wr & (act_idx == 2'h0);
  assign push_mst = stk_wr & (act_idx == 2'h1);
  assign push_usr = stk_wr & (act_idx == 2'h2);

  // Status word updates: move or logic immediate or exception return
  assign st_operand = is_flags ? ((reg_wdata[15:0] & SCR_FLAGS_MASK) | (stat_q & ~SCR_FLAGS_MASK))
                               : reg_wdata[15:0];
  assign st_result = (reg_op == SCR_OP_AND) ? (stat_q & (is_flags ? (st_operand | ~SCR_FLAGS_MASK) : st_operand)) :
                     (reg_op == SCR_OP_XOR) ? (stat_q ^ (st_operand & (is_flags ? SCR_FLAGS_MASK : 16'hFFFF))) :
                     (reg_op == SCR_OP_OR) ? (stat_q | (st_operand & (is_flags ? SCR_FLAGS_MASK : 16'hFFFF))) :
                     st_operand;
  assign st_written = st_result & SCR_ST_IMPL_MASK;

  // Interrupt entry: supervisor on, trace off, master cleared, mask set to exc_ipl
  assign st_exc = {2'h0, 1'h1, exc_is_irq ? 1'h0 : m_bit, 1'h0,
                   exc_is_irq ? exc_ipl : stat_q[SCR_ST_MASK_HI:SCR_ST_MASK_LO],
                   3'h0, stat_q[4:0]};

  // Register write wins over an implicit stack write to the same pointer
  assign int_sp_d = wr_int ? reg_wdata : (push_int ? stk_wdata : int_sp_q);
  assign mst_sp_d = wr_mst ? reg_wdata : (push_mst ? stk_wdata : mst_sp_q);
  assign usr_sp_d = wr_usr ? reg_wdata : (push_usr ? stk_wdata : usr_sp_q);
  assign vbase_d = wr_vbase ? reg_wdata : vbase_q;
  assign src_fc_d = wr_src ? reg_wdata[2:0] : src_fc_q;
  assign dst_fc_d = wr_dst ? reg_wdata[2:0] : dst_fc_q;
  assign cache_d = wr_cache ? (reg_wdata & SCR_CACHE_MASK) : cache_q;
  // Exception entry wins over a software status write in the same cycle
  assign stat_d = exc_start ? st_exc : (wr_status ? st_written : stat_q);

  assign rd_mux = sel_int ? int_sp_q :
                  sel_mst ? mst_sp_q :
                  sel_usr ? usr_sp_q :
                  sel_act ? (m_bit ? mst_sp_q : int_sp_q) :
                  sel_stat ? {16'h0000, stat_q} :
                  sel_vbase ? vbase_q :
                  sel_src ? {29'h0000000, src_fc_q} :
                  sel_dst ? {29'h0000000, dst_fc_q} :
                  sel_cache ? cache_q :
                  is_flags ? {16'h0000, stat_q & SCR_FLAGS_MASK} : 32'h00000000;

  // Interrupt stack pointer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      int_sp_q <= SCR_PTR_RESET;
    else if (clk_en)
      int_sp_q <= int_sp_d;
  end

  // Master stack pointer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      mst_sp_q <= SCR_PTR_RESET;
    else if (clk_en)
      mst_sp_q <= mst_sp_d;
  end

  // User stack pointer
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      usr_sp_q <= SCR_PTR_RESET;
    else if (clk_en)
      usr_sp_q <= usr_sp_d;
  end

  // Status word
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= SCR_ST_RESET;
    else if (clk_en)
      stat_q <= stat_d;
  end

  // Vector table base
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      vbase_q <= SCR_PTR_RESET;
    else if (clk_en)
      vbase_q <= vbase_d;
  end

  // Source alternate space code
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      src_fc_q <= SCR_FC_RESET;
    else if (clk_en)
      src_fc_q <= src_fc_d;
  end

  // Destination alternate space code
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dst_fc_q <= SCR_FC_RESET;
    else if (clk_en)
      dst_fc_q <= dst_fc_d;
  end

  // Cache enables
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cache_q <= SCR_CACHE_RESET;
    else if (clk_en)
      cache_q <= cache_d;
  end

  // Registered outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= SCR_DATA_RESET;
      fault_q <= 1'b0;
      saved_q <= SCR_SAVED_RESET;
      vec_q <= SCR_DATA_RESET;
      stk_q <= SCR_DATA_RESET;
      fc_q <= SCR_FC_RESET;
    end
    else if (clk_en)
    begin
      rdata_q <= rd_ok ? rd_mux : 32'h00000000;
      fault_q <= (reg_wr | reg_rd) & ~allowed;
      if (exc_start)
        saved_q <= stat_q;
      vec_q <= vbase_q + {22'h00000, vec_disp};
      stk_q <= act_ptr;
      fc_q <= fc_w;
    end
  end

  assign reg_rdata = rdata_q;
  assign priv_fault = fault_q;
  assign saved_status = saved_q;
  assign vec_addr = vec_q;
  assign stk_ptr = stk_q;
  assign space_code = fc_q;
  assign status_word = stat_q;
  assign sup_mode = stat_q[SCR_ST_SUP];
  assign icache_en = cache_q[SCR_CACHE_IE];
  assign dcache_en = cache_q[SCR_CACHE_DE];
endmodule

// [scr_regs_assertions.sv]
`timescale 1ns/100ps
module scr_regs_chk
(
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic priv_fault,
  // Exceptions and space codes
  input wire logic exc_start,
  input wire logic exc_is_irq,
  input wire logic [2:0] exc_ipl,
  input wire logic [15:0] saved_status,
  input wire logic prog_access,
  input wire logic use_alt_src,
  input wire logic use_alt_dst,
  input wire logic [2:0] space_code,
  // Mode and cache
  input wire logic [15:0] status_word,
  input wire logic sup_mode,
  input wire logic icache_en,
  input wire logic dcache_en
);
  import scr_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_sup; clk_en && (reg_wr || reg_rd) && sup_mode |=> !priv_fault; endproperty
  a_sup: assert property (p_sup) else $error("supervisor access refused");
  property p_irq; clk_en && exc_start && exc_is_irq |=> status_word[15:12] == 4'h2
    && status_word[10:8] == $past(exc_ipl); endproperty
  a_irq: assert property (p_irq) else $error("interrupt entry status wrong");
  property p_saved; clk_en && exc_start |=> saved_status == $past(status_word); endproperty
  a_saved: assert property (p_saved) else $error("saved status wrong");
  property p_fault; clk_en |=> priv_fault == $past((reg_wr || reg_rd) && !sup_mode
    && reg_addr != SCR_SEL_FLAGS); endproperty
  a_fault: assert property (p_fault) else $error("privilege fault pulse wrong");
  property p_m_stable; clk_en && !exc_start && !(reg_wr && reg_addr == SCR_SEL_STATUS)
    |=> $stable(status_word[SCR_ST_MST]); endproperty
  a_m_stable: assert property (p_m_stable) else $error("master bit changed");
  property p_user_blk; clk_en && reg_wr && !sup_mode && reg_addr != SCR_SEL_FLAGS && !exc_start
    |=> $stable(status_word) && $stable({dcache_en, icache_en}); endproperty
  a_user_blk: assert property (p_user_blk) else $error("user write not blocked");
  property p_cache_enable_reg; clk_en && reg_wr && sup_mode && reg_addr == SCR_SEL_CACHE
    |=> {dcache_en, icache_en} == {$past(reg_wdata[SCR_CACHE_DE]), $past(reg_wdata[SCR_CACHE_IE])}; endproperty
  a_cache_enable_reg: assert property (p_cache_enable_reg) else $error("cache enables wrong");
  property p_rdata_idle; clk_en && !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
  property p_space; clk_en && !use_alt_src && !use_alt_dst
    |=> space_code == {$past(sup_mode), $past(prog_access), !$past(prog_access)}; endproperty
  a_space: assert property (p_space) else $error("space code wrong");
  c_irq: cover property (exc_start && exc_is_irq);
  c_fault: cover property (priv_fault);
  c_cache: cover property (icache_en && dcache_en);
endmodule
bind scr_regs scr_regs_chk u_chk (.mclk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .priv_fault, .exc_start, .exc_is_irq, .exc_ipl, .saved_status, .prog_access,
  .use_alt_src, .use_alt_dst, .space_code, .status_word, .sup_mode, .icache_en, .dcache_en);

// [scr_regs_tb_top.sv]
`timescale 1ns/100ps
module scr_regs_tb_top;
  import scr_pkg::*;
  typedef struct {logic [3:0] wa; logic [31:0] wd; logic [3:0] ra; logic [31:0] ex;} scr_row_t;
  scr_row_t rows [10] = '{
    '{4'h0, 32'hA5A51234, 4'h3, 32'hA5A51234},
    '{4'h3, 32'h2468ACE0, 4'h0, 32'h2468ACE0},
    '{4'h1, 32'h13579BDF, 4'h1, 32'h13579BDF},
    '{4'h2, 32'h0F0FF0F0, 4'h2, 32'h0F0FF0F0},
    '{4'h5, 32'h00010000, 4'h5, 32'h00010000},
    '{4'h6, 32'hFFFFFFFF, 4'h6, 32'h00000007},
    '{4'h7, 32'h00000003, 4'h7, 32'h00000003},
    '{4'h8, 32'hFFFFFFFF, 4'h8, 32'h80008000},
    '{4'hF, 32'hDEADBEEF, 4'hF, 32'h00000000},
    '{4'h4, 32'h0000FFFF, 4'h3, 32'h13579BDF}};
  logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stk_wr = 1'b0;
  logic exc_start = 1'b0, exc_is_irq = 1'b0, prog_access = 1'b0, use_alt_src = 1'b0, use_alt_dst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, stk_wdata = 32'h0, reg_rdata, stk_ptr, vec_addr, got;
  logic [2:0] exc_ipl = 3'h0, space_code;
  logic [9:0] vec_disp = 10'h3FC;
  logic [15:0] saved_status, status_word;
  logic priv_fault, sup_mode, icache_en, dcache_en, pf;
  scr_op_t reg_op = SCR_OP_MOVE;
  int bad_count = 0, n_compared = 0;
  always #25 mclk = ~mclk;
  scr_regs uut (.mclk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_op, .reg_rdata,
    .priv_fault, .stk_wr, .stk_wdata, .stk_ptr, .exc_start, .exc_is_irq, .exc_ipl, .vec_disp,
    .saved_status, .vec_addr, .prog_access, .use_alt_src, .use_alt_dst, .space_code, .status_word,
    .sup_mode, .icache_en, .dcache_en);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input scr_op_t op);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    reg_op <= op;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    got = reg_rdata;
    pf = priv_fault;
  endtask
  task automatic st_op(input scr_op_t op, input logic [31:0] d, input logic [15:0] e);
    bus(1'b1, SCR_SEL_STATUS, d, op);
    chk(32'(status_word), 32'(e));
  endtask
  task automatic fc(input logic p, input logic s, input logic d, input logic [2:0] e);
    @(posedge mclk);
    prog_access <= p;
    use_alt_src <= s;
    use_alt_dst <= d;
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(space_code), 32'(e));
  endtask
  task automatic exc(input logic irq, input logic [2:0] ipl, input logic [15:0] es, input logic [15:0] ew);
    @(posedge mclk);
    exc_start <= 1'b1;
    exc_is_irq <= irq;
    exc_ipl <= ipl;
    @(posedge mclk);
    exc_start <= 1'b0;
    #1;
    chk(32'(saved_status), 32'(es));
    chk(32'(status_word), 32'(ew));
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk(32'(status_word), 32'h00002700);
    chk(32'({dcache_en, icache_en}), 32'h0);
    chk(32'(sup_mode), 32'h1);
    bus(1'b0, SCR_SEL_ACT_SP, 32'h0, SCR_OP_MOVE);
    chk(got, 32'h0);
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    do_reset;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].wa, rows[i].wd, SCR_OP_MOVE);
      chk(32'(pf), 32'h0);
      bus(1'b0, rows[i].ra, 32'h0, SCR_OP_MOVE);
      chk(got, rows[i].ex);
    end
    chk(32'(status_word), 32'h0000F71F);
    chk(vec_addr, 32'h000103FC);
    @(posedge mclk);
    stk_wr <= 1'b1;
    stk_wdata <= 32'h0BADF00D;
    @(posedge mclk);
    stk_wr <= 1'b0;
    bus(1'b0, SCR_SEL_MST_SP, 32'h0, SCR_OP_MOVE);
    chk(got, 32'h0BADF00D);
    fc(1'b0, 1'b0, 1'b0, SCR_FC_SUP_DATA);
    fc(1'b1, 1'b0, 1'b0, SCR_FC_SUP_PROG);
    fc(1'b0, 1'b1, 1'b1, 3'h7);
    fc(1'b0, 1'b0, 1'b1, 3'h3);
    exc(1'b0, 3'h2, 16'hF71F, 16'h371F);
    exc(1'b1, 3'h5, 16'h371F, 16'h251F);
    @(posedge mclk);
    #1;
    chk(stk_ptr, 32'h2468ACE0);
    st_op(SCR_OP_OR, 32'h00001000, 16'h351F);
    st_op(SCR_OP_XOR, 32'h00001000, 16'h251F);
    st_op(SCR_OP_AND, 32'h0000F70F, 16'h250F);
    st_op(SCR_OP_RET, 32'h0000371F, 16'h371F);
    st_op(SCR_OP_MOVE, 32'h00000004, 16'h0004);
    chk(32'(sup_mode), 32'h0);
    @(posedge mclk);
    #1;
    chk(stk_ptr, 32'h0F0FF0F0);
    fc(1'b0, 1'b0, 1'b0, SCR_FC_USER_DATA);
    fc(1'b1, 1'b0, 1'b0, SCR_FC_USER_PROG);
    bus(1'b1, SCR_SEL_CACHE, 32'h0, SCR_OP_MOVE);
    chk(32'({pf, dcache_en, icache_en}), 32'h7);
    bus(1'b0, SCR_SEL_VEC_BASE, 32'h0, SCR_OP_MOVE);
    chk({got[30:0], pf}, 32'h1);
    bus(1'b1, SCR_SEL_FLAGS, 32'h000000F0, SCR_OP_OR);
    chk(32'({pf, status_word}), 32'h00000014);
    bus(1'b1, SCR_SEL_STATUS, 32'h00002700, SCR_OP_MOVE);
    chk(32'({pf, status_word}), 32'h00010014);
    @(posedge mclk);
    do_reset;
    results;
  end
endmodule

// [scr_stack_sel.sv]
`timescale 1ns/100ps
module scr_stack_sel
(
  // Mode bits
  input wire logic sup_mode,
  input wire logic master_mode,
  // Stack pointers
  input wire logic [31:0] user_stack_ptr,
  input wire logic [31:0] interrupt_stack_ptr,
  input wire logic [31:0] master_stack_ptr,
  // Selection
  output logic [31:0] active_ptr,
  output logic [1:0] active_idx
);
  wire logic [31:0] sup_ptr;
  assign sup_ptr = master_mode ? master_stack_ptr : interrupt_stack_ptr;
  assign active_ptr = sup_mode ? sup_ptr : user_stack_ptr;
  assign active_idx = sup_mode ? (master_mode ? 2'h1 : 2'h0) : 2'h2;
endmodule
